// ---- routing_mirror_registers.sv ----
// routing mirror register bank with ingress control and window lookup
// What this block does
// - io mirror capability nibbles 3:0 and 11:8 read-only 1h.
// - io mirror bits 7:4 writable io base copy, reset Fh.
// - io mirror bits 15:12 io limit copy, reset 0; bits 31:16 read zero.
// - memory mirror base 15:4 reset FFFh, limit 31:20 reset 000h, rest zero.
// - prefetch mirror capability nibbles 3:0 and 19:16 read-only, reset 1h.
// - prefetch mirror base 15:4 reset FFFh, limit 31:20 reset 000h, writable.
// - prefetch base upper 32 bits register, writable, reset all ones.
// - prefetch limit upper 32 bits register, writable, reset all zeros.
// - reverse mode: downstream config accepted only while ingress bit 0 set.
// - ingress bit 1 set suppresses unsupported-request on device-specific writes.
// - test port enable register, 32-bit writable, reset all ones, no function.
// - upper io mirror: base 15:0 low half FFFFh, limit 31:16 high half 0000h.
// - mirrors except the prefetch capability nibbles follow primary window registers automatically on every change.
// - io mirror routes io requests, address map mirrors route memory requests.
`timescale 1ns/10ps
module routing_mirror_registers
	import mirror_pkg::*;
(
	input  wire logic                  clock,
	input  wire logic                  rst_n,
	input  mirror_pkg::cfg_req_t       cfg_req,
	output mirror_pkg::cfg_rsp_t       cfg_rsp,
	input  wire logic                  eeprom_load,
	input  wire logic [11:0]           eeprom_addr,
	input  wire logic [31:0]           eeprom_data,
	input  wire logic                  shadow_update,
	input  mirror_pkg::windows_t       shadow_windows,
	input  wire logic                  reverse_mode,
	input  wire logic                  ds_cfg_valid,
	output logic                       ds_cfg_accept,
	output logic                       ds_cfg_reject,
	input  mirror_pkg::route_req_t     route_req,
	output mirror_pkg::route_rsp_t     route_rsp
);
	`include "mirror_defs.svh"

	typedef struct packed {
		windows_t   win;
		logic [31:0] ingress;
		logic [31:0] port_test;
		cfg_rsp_t   rsp;
		logic       ds_accept;
		logic       ds_reject;
		route_rsp_t route;
	} state_t;

	state_t s_q;
	state_t s_d;

	// register images assembled once, used by read mux and writes
	function automatic logic [31:0] reg_image(input windows_t w, input logic [31:0] ing,
		input logic [31:0] pt, input logic [11:0] a, output logic hit);
		hit = 1'b1;
		case (a)
			`OFS_IO_WINDOW_MIRROR: reg_image = {16'h0000, w.io_limit, `IO_CAP_32BIT,
				w.io_base, `IO_CAP_32BIT};
			`OFS_MEM_WINDOW_MIRROR: reg_image = {w.mem_limit, 4'h0, w.mem_base, 4'h0};
			`OFS_PREF_WINDOW_MIRROR_LOW: reg_image = {w.pref_limit, w.pref_limit_cap,
				w.pref_base, w.pref_base_cap};
			`OFS_PREF_BASE_MIRROR_HIGH: reg_image = w.pref_base_hi;
			`OFS_PREF_LIMIT_MIRROR_HIGH: reg_image = w.pref_limit_hi;
			`OFS_INGRESS_CONTROL: reg_image = ing;
			`OFS_INGRESS_PORT_TEST_EN: reg_image = pt;
			`OFS_IO_WINDOW_MIRROR_UPPER: reg_image = {w.io_limit_up, w.io_base_up};
			default: begin
				reg_image = 32'h0000_0000;
				hit = 1'b0;
			end
		endcase
	endfunction : reg_image

	function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			merge_be[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction : merge_be

	// write one merged word into its register; read-only nibbles are simply dropped
	function automatic state_t store(input state_t s, input logic [11:0] a,
		input logic [31:0] v);
		state_t r;
		r = s;
		case (a)
			`OFS_IO_WINDOW_MIRROR: begin
				r.win.io_base  = v[7:4];
				r.win.io_limit = v[15:12];
			end
			`OFS_MEM_WINDOW_MIRROR: begin
				r.win.mem_base  = v[15:4];
				r.win.mem_limit = v[31:20];
			end
			`OFS_PREF_WINDOW_MIRROR_LOW: begin
				r.win.pref_base  = v[15:4];
				r.win.pref_limit = v[31:20];
			end
			`OFS_PREF_BASE_MIRROR_HIGH: r.win.pref_base_hi = v;
			`OFS_PREF_LIMIT_MIRROR_HIGH: r.win.pref_limit_hi = v;
			`OFS_INGRESS_CONTROL: r.ingress = v;
			`OFS_INGRESS_PORT_TEST_EN: r.port_test = v;
			`OFS_IO_WINDOW_MIRROR_UPPER: begin
				r.win.io_base_up  = v[15:0];
				r.win.io_limit_up = v[31:16];
			end
			default: r = s;
		endcase
		return r;
	endfunction : store

	logic [63:0] io_base_full;
	logic [63:0] io_limit_full;
	logic [63:0] mem_base_full;
	logic [63:0] mem_limit_full;
	logic [63:0] pref_base_full;
	logic [63:0] pref_limit_full;
	logic        hit_io;
	logic        hit_mem;
	logic        hit_pref;

	// low bits of each base pad with zeros, of each limit with ones
	assign io_base_full    = {32'h0000_0000, s_q.win.io_base_up, s_q.win.io_base, 12'h000};
	assign io_limit_full   = {32'h0000_0000, s_q.win.io_limit_up, s_q.win.io_limit, 12'hfff};
	assign mem_base_full   = {32'h0000_0000, s_q.win.mem_base, 20'h0_0000};
	assign mem_limit_full  = {32'h0000_0000, s_q.win.mem_limit, 20'hf_ffff};
	// 32-bit prefetch capability ignores the upper mirrors
	assign pref_base_full  = {(s_q.win.pref_base_cap == `PREF_CAP_64BIT) ?
		s_q.win.pref_base_hi : 32'h0000_0000, s_q.win.pref_base, 20'h0_0000};
	assign pref_limit_full = {(s_q.win.pref_limit_cap == `PREF_CAP_64BIT) ?
		s_q.win.pref_limit_hi : 32'h0000_0000, s_q.win.pref_limit, 20'hf_ffff};

	window_match #(.W(64)) u_io (
		.addr  (route_req.addr),
		.base  (io_base_full),
		.limit (io_limit_full),
		.hit   (hit_io)
	);
	window_match #(.W(64)) u_mem (
		.addr  (route_req.addr),
		.base  (mem_base_full),
		.limit (mem_limit_full),
		.hit   (hit_mem)
	);
	window_match #(.W(64)) u_pref (
		.addr  (route_req.addr),
		.base  (pref_base_full),
		.limit (pref_limit_full),
		.hit   (hit_pref)
	);

	always_comb begin
		logic [31:0] old_v;
		logic        mapped;
		logic        dummy;
		wsrc_t       src;
		s_d    = s_q;
		old_v  = 32'h0000_0000;
		mapped = 1'b0;
		dummy  = 1'b0;
		src    = wsrc_none;
		// primary window change wins over eeprom and software in the same cycle
		if (shadow_update) begin
			src = wsrc_shadow;
		end else if (eeprom_load) begin
			src = wsrc_eeprom;
		end else if (cfg_req.valid && cfg_req.write) begin
			src = wsrc_cfg;
		end
		case (src)
			wsrc_shadow: begin
				s_d.win = shadow_windows;
				s_d.win.pref_base_cap  = s_q.win.pref_base_cap;
				s_d.win.pref_limit_cap = s_q.win.pref_limit_cap;
			end
			wsrc_eeprom: begin
				old_v = reg_image(s_q.win, s_q.ingress, s_q.port_test, eeprom_addr, dummy);
				s_d = store(s_q, eeprom_addr, eeprom_data);
				// eeprom may also preset the prefetch capability nibbles
				if (eeprom_addr == `OFS_PREF_WINDOW_MIRROR_LOW) begin
					s_d.win.pref_base_cap  = eeprom_data[3:0];
					s_d.win.pref_limit_cap = eeprom_data[19:16];
				end
			end
			wsrc_cfg: begin
				old_v = reg_image(s_q.win, s_q.ingress, s_q.port_test, cfg_req.addr, dummy);
				s_d = store(s_q, cfg_req.addr, merge_be(old_v, cfg_req.wdata, cfg_req.be));
			end
			default: s_d = s_q;
		endcase

		// answer every config access one cycle later; unmapped reads return zero
		s_d.rsp.valid = cfg_req.valid;
		s_d.rsp.rdata = reg_image(s_q.win, s_q.ingress, s_q.port_test, cfg_req.addr,
			mapped);
		if (!cfg_req.write) begin
			s_d.rsp.ur = 1'b0;
		end else begin
			s_d.rsp.ur = !mapped && !s_q.ingress[`ING_NO_UR_BIT];
		end
		if (!cfg_req.valid) begin
			s_d.rsp.rdata = 32'h0000_0000;
			s_d.rsp.ur    = 1'b0;
		end

		// downstream config gate only meaningful in reverse mode
		s_d.ds_accept = ds_cfg_valid && reverse_mode && s_q.ingress[`ING_CFG_ACCEPT_BIT];
		s_d.ds_reject = ds_cfg_valid && reverse_mode && !s_q.ingress[`ING_CFG_ACCEPT_BIT];

		s_d.route.valid    = route_req.valid;
		s_d.route.hit_io   = route_req.valid && route_req.is_io && hit_io;
		s_d.route.hit_mem  = route_req.valid && !route_req.is_io && hit_mem;
		s_d.route.hit_pref = route_req.valid && !route_req.is_io && hit_pref;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s_q                    <= '0;
			s_q.win.io_base        <= `RST_IO_BASE;
			s_q.win.io_limit       <= `RST_IO_LIMIT;
			s_q.win.io_base_up     <= `RST_IO_BASE_UP;
			s_q.win.io_limit_up    <= `RST_IO_LIMIT_UP;
			s_q.win.mem_base       <= `RST_MEM_BASE;
			s_q.win.mem_limit      <= `RST_MEM_LIMIT;
			s_q.win.pref_base_cap  <= `RST_PREF_CAP;
			s_q.win.pref_limit_cap <= `RST_PREF_CAP;
			s_q.win.pref_base      <= `RST_PREF_BASE;
			s_q.win.pref_limit     <= `RST_PREF_LIMIT;
			s_q.win.pref_base_hi   <= `RST_PREF_BASE_HI;
			s_q.win.pref_limit_hi  <= `RST_PREF_LIMIT_HI;
			s_q.ingress            <= `RST_INGRESS_CONTROL;
			s_q.port_test          <= `RST_PORT_TEST_EN;
		end else begin
			s_q <= s_d;
		end
	end

	assign cfg_rsp       = s_q.rsp;
	assign ds_cfg_accept = s_q.ds_accept;
	assign ds_cfg_reject = s_q.ds_reject;
	assign route_rsp     = s_q.route;
endmodule : routing_mirror_registers

// ---- mirror_defs.svh ----
// register offsets, field positions and reset values of the routing mirror bank
`ifndef MIRROR_DEFS_SVH
`define MIRROR_DEFS_SVH

`define OFS_IO_WINDOW_MIRROR        12'h318
`define OFS_MEM_WINDOW_MIRROR       12'h3c8
`define OFS_PREF_WINDOW_MIRROR_LOW  12'h3cc
`define OFS_PREF_BASE_MIRROR_HIGH   12'h3d0
`define OFS_PREF_LIMIT_MIRROR_HIGH  12'h3d4
`define OFS_INGRESS_CONTROL         12'h660
`define OFS_INGRESS_PORT_TEST_EN    12'h668
`define OFS_IO_WINDOW_MIRROR_UPPER  12'h6a0

`define IO_CAP_32BIT                4'h1
`define PREF_CAP_32BIT              4'h0
`define PREF_CAP_64BIT              4'h1

`define RST_IO_BASE                 4'hf
`define RST_IO_LIMIT                4'h0
`define RST_MEM_BASE                12'hfff
`define RST_MEM_LIMIT               12'h000
`define RST_PREF_CAP                4'h1
`define RST_PREF_BASE               12'hfff
`define RST_PREF_LIMIT              12'h000
`define RST_PREF_BASE_HI            32'hffff_ffff
`define RST_PREF_LIMIT_HI           32'h0000_0000
`define RST_INGRESS_CONTROL         32'h0000_0000
`define RST_PORT_TEST_EN            32'hffff_ffff
`define RST_IO_BASE_UP              16'hffff
`define RST_IO_LIMIT_UP             16'h0000

`define ING_CFG_ACCEPT_BIT          0
`define ING_NO_UR_BIT               1

`endif

// ---- mirror_pkg.sv ----
// types shared by the routing mirror bank
package mirror_pkg;
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [11:0] addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} cfg_req_t;

	typedef struct packed {
		logic        valid;
		logic        ur;
		logic [31:0] rdata;
	} cfg_rsp_t;

	typedef struct packed {
		logic        valid;
		logic        is_io;
		logic [63:0] addr;
	} route_req_t;

	typedef struct packed {
		logic valid;
		logic hit_io;
		logic hit_mem;
		logic hit_pref;
	} route_rsp_t;

	typedef struct packed {
		logic [3:0]  io_base;
		logic [3:0]  io_limit;
		logic [15:0] io_base_up;
		logic [15:0] io_limit_up;
		logic [11:0] mem_base;
		logic [11:0] mem_limit;
		logic [3:0]  pref_base_cap;
		logic [3:0]  pref_limit_cap;
		logic [11:0] pref_base;
		logic [11:0] pref_limit;
		logic [31:0] pref_base_hi;
		logic [31:0] pref_limit_hi;
	} windows_t;

	typedef enum logic [1:0] {
		wsrc_none   = 2'b00,
		wsrc_cfg    = 2'b01,
		wsrc_shadow = 2'b10,
		wsrc_eeprom = 2'b11
	} wsrc_t;
endpackage : mirror_pkg

// ---- window_match.sv ----
// combinational window compare on mirrored base and limit
`timescale 1ns/10ps
module window_match #(
	parameter int W = 64
) (
	input  wire logic [W-1:0] addr,
	input  wire logic [W-1:0] base,
	input  wire logic [W-1:0] limit,
	output logic              hit
);
	// inclusive at both ends; base above limit never hits
	assign hit = (addr >= base) && (addr <= limit);
endmodule : window_match

// ---- cfg_host.sv ----
// configuration requester model for the routing mirror bank
`timescale 1ns/10ps
module cfg_host (
	input  wire logic           clock,
	output mirror_pkg::cfg_req_t cfg_req,
	input  mirror_pkg::cfg_rsp_t cfg_rsp
);
	import mirror_pkg::*;
	initial cfg_req = '0;
	// one access: taken on the edge after it is driven, answer one cycle later
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
		output cfg_rsp_t r, input logic [3:0] b);
		@(posedge clock);
		cfg_req <= '{valid: 1'b1, write: w, addr: a, be: b, wdata: d};
		@(posedge clock);
		// released lines show the inverse, not the stale value
		cfg_req <= '{valid: 1'b0, write: ~w, addr: ~a, be: 4'h0, wdata: ~d};
		#1 r = cfg_rsp;
	endtask : acc
endmodule : cfg_host

// ---- routing_mirror_registers_monitor.sv ----
// port assertions for the routing mirror bank
`timescale 1ns/10ps
module mirror_monitor (
	input wire logic             clock,
	input wire logic             rst_n,
	input mirror_pkg::cfg_req_t   cfg_req,
	input mirror_pkg::cfg_rsp_t   cfg_rsp,
	input wire logic             reverse_mode,
	input wire logic             ds_cfg_valid,
	input wire logic             ds_cfg_accept,
	input wire logic             ds_cfg_reject,
	input mirror_pkg::route_req_t route_req,
	input mirror_pkg::route_rsp_t route_rsp
);
	import mirror_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire logic rd = cfg_req.valid && !cfg_req.write;
	property p_io_cap;
		rd && cfg_req.addr == 12'h318 |=> cfg_rsp.valid && cfg_rsp.rdata[11:8] == 4'h1
			&& cfg_rsp.rdata[3:0] == 4'h1;
	endproperty
	a_io_cap: assert property (p_io_cap) else $error("io cap nibble");
	property p_io_rsv; rd && cfg_req.addr == 12'h318 |=> cfg_rsp.rdata[31:16] == 16'h0; endproperty
	a_io_rsv: assert property (p_io_rsv) else $error("io upper half");
	property p_mem_rsv;
		rd && cfg_req.addr == 12'h3c8 |=> cfg_rsp.rdata[19:16] == 4'h0 && cfg_rsp.rdata[3:0] == 4'h0;
	endproperty
	a_mem_rsv: assert property (p_mem_rsv) else $error("mem reserved");
	property p_pref_cap;
		rd && cfg_req.addr == 12'h3cc |=> cfg_rsp.rdata[3:0] <= 4'h1 && cfg_rsp.rdata[19:16] <= 4'h1;
	endproperty
	a_pref_cap: assert property (p_pref_cap) else $error("pref cap code");
	property p_ds_off; !reverse_mode && ds_cfg_valid |=> !ds_cfg_accept && !ds_cfg_reject; endproperty
	a_ds_off: assert property (p_ds_off) else $error("ds answer off");
	property p_ds_one; reverse_mode && ds_cfg_valid |=> ds_cfg_accept ^ ds_cfg_reject; endproperty
	a_ds_one: assert property (p_ds_one) else $error("ds answer count");
	property p_rd_ur; rd |=> cfg_rsp.valid && !cfg_rsp.ur; endproperty
	a_rd_ur: assert property (p_rd_ur) else $error("read flagged");
	property p_io_route;
		route_req.valid && route_req.is_io |=> route_rsp.valid && !route_rsp.hit_mem
			&& !route_rsp.hit_pref;
	endproperty
	a_io_route: assert property (p_io_route) else $error("io routed as mem");
	property p_mem_route; route_req.valid && !route_req.is_io |=> route_rsp.valid && !route_rsp.hit_io;
	endproperty
	a_mem_route: assert property (p_mem_route) else $error("mem routed as io");
	c_accept: cover property (ds_cfg_accept);
	c_ur: cover property (cfg_rsp.ur);
	c_pref: cover property (route_rsp.hit_pref);
endmodule : mirror_monitor
bind routing_mirror_registers mirror_monitor u_mirror_monitor (.clock, .rst_n, .cfg_req,
	.cfg_rsp, .reverse_mode, .ds_cfg_valid, .ds_cfg_accept, .ds_cfg_reject, .route_req,
	.route_rsp);

// ---- tb.sv ----
// self-checking bench for the routing mirror bank
`timescale 1ns/10ps
module tb;
	import mirror_pkg::*;
	logic clock = 1'b0, rst_n = 1'b0, eeprom_load = 1'b0, shadow_update = 1'b0;
	logic reverse_mode = 1'b0, ds_cfg_valid = 1'b0, ds_cfg_accept, ds_cfg_reject;
	logic [11:0] eeprom_addr = 12'h000;
	logic [31:0] eeprom_data = 32'h0000_0000;
	windows_t shadow_windows = '0;
	route_req_t route_req = '0;
	route_rsp_t route_rsp;
	cfg_req_t cfg_req;
	cfg_rsp_t cfg_rsp;
	int error_cnt = 0, n_compared = 0;
	logic [11:0] ad [8] = '{12'h318, 12'h3c8, 12'h3cc, 12'h3d0, 12'h3d4, 12'h660, 12'h668, 12'h6a0};
	logic [31:0] rs [8] = '{32'h0000_01f1, 32'h0000_fff0, 32'h0001_fff1, 32'hffff_ffff,
		32'h0000_0000, 32'h0000_0000, 32'hffff_ffff, 32'h0000_ffff};
	logic [31:0] on [8] = '{32'h0000_f1f1, 32'hfff0_fff0, 32'hfff1_fff1, 32'hffff_ffff,
		32'hffff_ffff, 32'h0000_0003, 32'hffff_ffff, 32'hffff_ffff};
	logic [31:0] ze [8] = '{32'h0000_0101, 32'h0, 32'h0001_0001, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
	always #50 clock = ~clock;
	routing_mirror_registers u_routing_mirror_registers (.clock, .rst_n, .cfg_req, .cfg_rsp,
		.eeprom_load, .eeprom_addr, .eeprom_data, .shadow_update, .shadow_windows,
		.reverse_mode, .ds_cfg_valid, .ds_cfg_accept, .ds_cfg_reject, .route_req, .route_rsp);
	cfg_host u_cfg_host (.clock, .cfg_req, .cfg_rsp);
	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// write data is not compared: the answer carries the old image
	task automatic xs(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic u, input logic [31:0] e, input logic [3:0] b = 4'hf);
		cfg_rsp_t r;
		u_cfg_host.acc(w, a, d, r, b);
		chk({r.valid, r.ur, w ? 32'h0 : r.rdata}, {1'b1, u, w ? 32'h0 : e});
	endtask : xs
	task automatic ds(input logic [1:0] e);
		@(posedge clock) ds_cfg_valid <= 1'b1;
		@(posedge clock) ds_cfg_valid <= 1'b0;
		#1 chk({32'h0, ds_cfg_accept, ds_cfg_reject}, {32'h0, e});
	endtask : ds
	task automatic rt(input logic io, input logic [63:0] a, input logic [2:0] e);
		@(posedge clock) route_req <= '{valid: 1'b1, is_io: io, addr: a};
		@(posedge clock) route_req <= '{valid: 1'b0, is_io: ~io, addr: ~a};
		#1 chk({30'h0, route_rsp}, {30'h0, 1'b1, e});
	endtask : rt
	task automatic ee(input logic [11:0] a, input logic [31:0] d);
		@(posedge clock) begin
			eeprom_addr <= a;
			eeprom_data <= d;
			eeprom_load <= 1'b1;
		end
		@(posedge clock) eeprom_load <= 1'b0;
	endtask : ee
	task automatic conclude();
		$display("compared=%0d errors=%0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : conclude
	initial begin
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			xs(1'b0, ad[i], 32'h0, 1'b0, rs[i]);
			xs(1'b1, ad[i], (i == 5) ? 32'h0000_0003 : 32'hffff_ffff, 1'b0, 32'h0);
			xs(1'b0, ad[i], 32'h0, 1'b0, on[i]);
			xs(1'b1, ad[i], 32'h0, 1'b0, 32'h0);
			xs(1'b0, ad[i], 32'h0, 1'b0, ze[i]);
		end
		$display("done: registers");
		xs(1'b1, 12'h664, 32'h1, 1'b1, 32'h0);
		xs(1'b0, 12'h664, 32'h0, 1'b0, 32'h0);
		xs(1'b1, 12'h660, 32'h2, 1'b0, 32'h0);
		xs(1'b1, 12'h664, 32'h1, 1'b0, 32'h0);
		@(posedge clock) reverse_mode <= 1'b1;
		ds(2'b01);
		xs(1'b1, 12'h660, 32'h1, 1'b0, 32'h0);
		ds(2'b10);
		@(posedge clock) reverse_mode <= 1'b0;
		ds(2'b00);
		$display("done: ingress");
		// capability nibbles offered as zero must stay at one
		@(posedge clock) begin
			shadow_windows <= '{4'h2, 4'h3, 16'h0, 16'h0, 12'h100, 12'h1ff, 4'h0, 4'h0,
				12'h200, 12'h2ff, 32'h1, 32'h1};
			shadow_update <= 1'b1;
		end
		@(posedge clock) shadow_update <= 1'b0;
		xs(1'b0, 12'h318, 32'h0, 1'b0, 32'h0000_3121);
		xs(1'b0, 12'h3cc, 32'h0, 1'b0, 32'h2ff1_2001);
		rt(1'b1, 64'h3fff, 3'b100);
		rt(1'b1, 64'h4000, 3'b000);
		rt(1'b1, 64'h1000_0000, 3'b000);
		rt(1'b0, 64'h1000_0000, 3'b010);
		rt(1'b0, 64'h0fff_ffff, 3'b000);
		rt(1'b0, 64'h1_2000_0000, 3'b001);
		rt(1'b0, 64'h1_2fff_ffff, 3'b001);
		rt(1'b0, 64'h1_3000_0000, 3'b000);
		$display("done: routing");
		ee(12'h3d4, 32'h0000_0002);
		xs(1'b0, 12'h3d4, 32'h0, 1'b0, 32'h0000_0002);
		// capability nibbles preset to 32-bit: upper mirrors drop out of the compare
		ee(12'h3cc, 32'h2ff0_2000);
		xs(1'b0, 12'h3cc, 32'h0, 1'b0, 32'h2ff0_2000);
		rt(1'b0, 64'h2000_0000, 3'b001);
		rt(1'b0, 64'h1_2000_0000, 3'b000);
		xs(1'b1, 12'h3cc, 32'hffff_ffff, 1'b0, 32'h0);
		xs(1'b0, 12'h3cc, 32'h0, 1'b0, 32'hfff0_fff0);
		$display("done: eeprom");
		// partial byte enables keep the unselected bytes
		xs(1'b1, 12'h3d0, 32'h1234_5678, 1'b0, 32'h0, 4'b0101);
		xs(1'b0, 12'h3d0, 32'h0, 1'b0, 32'h0034_0078);
		$display("done: byte enables");
		conclude();
	end
	// whole run is about 150 cycles
	initial begin
		repeat (5000) @(posedge clock);
		error_cnt++;
		conclude();
	end
endmodule : tb
